// file: tso_params.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * 16-bit timer with square-wave and one-shot pulse output.
 * Assumes an APB slave with byte addresses and 32-bit data.
 */
`ifndef TSO_PARAMS_SVH
`define TSO_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define TSO_OFF_MODE    8'h00
`define TSO_OFF_CAPCMP  8'h04
`define TSO_OFF_OUTCTL  8'h08
`define TSO_OFF_PRESC   8'h0C
`define TSO_OFF_COUNT   8'h10
`define TSO_OFF_CMPA    8'h14
`define TSO_OFF_CMPB    8'h18
`define TSO_OFF_STATUS  8'h1C

// ****************************************************************
// Field positions
// ****************************************************************
`define TSO_MODE_LO     2
`define TSO_MODE_HI     3
`define TSO_CC_A_CAP    0
`define TSO_CC_B_CAP    2
`define TSO_OC_OE       0
`define TSO_OC_TOG      1
`define TSO_OC_OS_EN    4
`define TSO_OC_EXT_EN   5
`define TSO_OC_SW_TRIG  6
`define TSO_PR_DIV_LO   0
`define TSO_PR_DIV_HI   1
`define TSO_PR_ES_LO    4
`define TSO_PR_ES_HI    5
`define TSO_ST_MATCH_A  0
`define TSO_ST_MATCH_B  1
`define TSO_ST_OVF      2
`define TSO_ST_ACTIVE   3

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define TSO_RST_COUNT   16'h0000
`define TSO_RST_CMP     16'h0000
`define TSO_CNT_MAX     16'hFFFF
`define TSO_DIV_W       4

`endif

// file: tso_pkg.sv
/*
 * Types shared by the timer and its trigger edge detector.
 * Assumes tso_params.svh supplies the widths.
 */
`include "tso_params.svh"

package tso_pkg;

    typedef enum logic [1:0] {
        TSO_STOP      = 2'b00,
        TSO_FREE      = 2'b01,
        TSO_TRIG_CLR  = 2'b10,
        TSO_MATCH_CLR = 2'b11
    } tso_mode_t;

    typedef enum logic [1:0] {
        TSO_EDGE_FALL = 2'b00,
        TSO_EDGE_RISE = 2'b01,
        TSO_EDGE_NONE = 2'b10,
        TSO_EDGE_BOTH = 2'b11
    } tso_edge_t;

    typedef struct packed {
        tso_mode_t              mode;
        logic                   a_cap;
        logic                   b_cap;
        logic                   oe;
        logic                   tog;
        logic                   os_en;
        logic                   ext_en;
        logic [1:0]             div_sel;
        tso_edge_t              edge_sel;
        logic [15:0]            count;
        logic [15:0]            cmp_a;
        logic [15:0]            cmp_b;
        logic [`TSO_DIV_W-1:0]  div;
        logic                   flag_a;
        logic                   flag_b;
        logic                   ovf;
        logic                   active;
        logic                   out;
        logic                   irq_a;
        logic                   irq_b;
        logic [31:0]            rdata;
    } tso_state_t;

    typedef struct packed {
        logic [1:0] smp;
        logic       level;
        logic       edge_p;
    } tso_det_t;

endpackage

// file: tso_trig_if.sv
/*
 * Carrier between the timer core and its trigger edge detector.
 * Assumes both ends share pclk.
 */
interface tso_trig_if;
    logic                cnt_en;
    logic                trig_in;
    logic                running;
    tso_pkg::tso_edge_t  edge_sel;
    logic                valid_edge;

    modport ctrl (
        output cnt_en,
        output trig_in,
        output running,
        output edge_sel,
        input  valid_edge
    );

    modport det (
        input  cnt_en,
        input  trig_in,
        input  running,
        input  edge_sel,
        output valid_edge
    );
endinterface

// file: tso_trig_edge.sv
/*
 * Trigger input edge detector with a two-sample noise filter.
 * Assumes the trigger pin is synchronous to pclk and that cnt_en
 * is the one-cycle count clock enable.
 */
`include "tso_params.svh"

module tso_trig_edge (
    // Clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // Core side
    tso_trig_if.det    bus
);

    tso_pkg::tso_det_t q;
    tso_pkg::tso_det_t d;

    // ****************************************************************
    // Filter and edge select
    // ****************************************************************
    // A level counts only after two equal samples on the count
    // clock, so pulses shorter than one count period are lost.
    always_comb begin
        d = q;
        d.edge_p = 1'b0;
        if (bus.cnt_en) begin
            d.smp = {q.smp[0], bus.trig_in};
            if (q.smp[1] == q.smp[0] && q.smp[0] != q.level) begin
                d.level = q.smp[0];
                unique case (bus.edge_sel)
                    tso_pkg::TSO_EDGE_FALL: d.edge_p = ~q.smp[0];
                    tso_pkg::TSO_EDGE_RISE: d.edge_p = q.smp[0];
                    tso_pkg::TSO_EDGE_NONE: d.edge_p = 1'b0;
                    tso_pkg::TSO_EDGE_BOTH: d.edge_p = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bus.valid_edge = q.edge_p & bus.running;

    chk_rise_edge_seen: assert property (
        @(posedge pclk) disable iff (!presetn)
        bus.cnt_en && bus.running && q.smp == 2'b11 && !q.level &&
        bus.edge_sel == tso_pkg::TSO_EDGE_RISE |=> bus.valid_edge
    ) else $error("rising trigger edge not reported");

endmodule

// file: tso_timer.sv
/*
 * 16-bit timer with input capture, square-wave output and one-shot
 * pulse output by software or trigger pin, as an APB slave.
 * Assumes a zero-wait APB master and pins synchronous to pclk.
 */
`include "tso_params.svh"

module tso_timer (
    // APB slave
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // Pins
    input  wire logic         trigger_input,
    output logic              timer_output,
    // Match requests
    output logic              match_a_irq,
    output logic              match_b_irq
);

    tso_pkg::tso_state_t s_q;
    tso_pkg::tso_state_t s_d;
    tso_trig_if          trig_if ();

    logic                  setup;
    logic                  wr;
    logic                  mapped;
    logic                  running;
    logic [`TSO_DIV_W-1:0] div_mask;
    logic                  tick;
    logic                  ext_os;
    logic                  a_cap_eff;
    logic                  b_cap_eff;
    logic                  match_a;
    logic                  match_b;
    logic [15:0]           lo;
    logic [15:0]           hi;
    logic                  valid_edge;
    logic                  trig_clear;
    logic                  sw_trig;
    logic [31:0]           rd_val;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pwrite;
    assign mapped  = (paddr[1:0] == 2'h0) && (paddr[7:5] == 3'h0);
    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~mapped;
    assign sw_trig = wr && mapped && paddr == `TSO_OFF_OUTCTL &&
                     pwdata[`TSO_OC_SW_TRIG];

    // ****************************************************************
    // Count clock and match detection
    // ****************************************************************
    // The divider runs free, so a start lands anywhere in a count
    // period and the first match may come up to one period late.
    assign running  = s_q.mode != tso_pkg::TSO_STOP;
    assign div_mask = `TSO_DIV_W'((5'h02 << s_q.div_sel) - 5'h01);
    assign tick     = running && ((s_q.div & div_mask) == div_mask);

    // External one-shot keeps both registers in compare use
    assign ext_os    = s_q.os_en && s_q.ext_en &&
                       s_q.mode == tso_pkg::TSO_TRIG_CLR;
    assign a_cap_eff = s_q.a_cap & ~ext_os;
    assign b_cap_eff = s_q.b_cap & ~ext_os;

    assign match_a = tick && !a_cap_eff && s_q.count == s_q.cmp_a;
    assign match_b = tick && !b_cap_eff && s_q.count == s_q.cmp_b;

    // The earlier compare value opens the pulse, the later closes it
    assign lo = (s_q.cmp_b < s_q.cmp_a) ? s_q.cmp_b : s_q.cmp_a;
    assign hi = (s_q.cmp_b < s_q.cmp_a) ? s_q.cmp_a : s_q.cmp_b;

    // ****************************************************************
    // Trigger input
    // ****************************************************************
    assign trig_if.cnt_en   = tick;
    assign trig_if.trig_in  = trigger_input;
    assign trig_if.running  = running;
    assign trig_if.edge_sel = s_q.edge_sel;
    assign valid_edge       = trig_if.valid_edge;

    tso_trig_edge u_det (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (trig_if.det)
    );

    // Edges during an external pulse are dropped, not queued
    assign trig_clear = valid_edge &&
                        s_q.mode == tso_pkg::TSO_TRIG_CLR &&
                        !(ext_os && s_q.active);

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always_comb begin
        rd_val = '0;
        case (paddr)
            `TSO_OFF_MODE: begin
                rd_val[`TSO_MODE_HI:`TSO_MODE_LO] = s_q.mode;
            end
            `TSO_OFF_CAPCMP: begin
                rd_val[`TSO_CC_A_CAP] = s_q.a_cap;
                rd_val[`TSO_CC_B_CAP] = s_q.b_cap;
            end
            `TSO_OFF_OUTCTL: begin
                rd_val[`TSO_OC_OE]     = s_q.oe;
                rd_val[`TSO_OC_TOG]    = s_q.tog;
                rd_val[`TSO_OC_OS_EN]  = s_q.os_en;
                rd_val[`TSO_OC_EXT_EN] = s_q.ext_en;
            end
            `TSO_OFF_PRESC: begin
                rd_val[`TSO_PR_DIV_HI:`TSO_PR_DIV_LO] = s_q.div_sel;
                rd_val[`TSO_PR_ES_HI:`TSO_PR_ES_LO]   = s_q.edge_sel;
            end
            `TSO_OFF_COUNT:  rd_val[15:0] = s_q.count;
            `TSO_OFF_CMPA:   rd_val[15:0] = s_q.cmp_a;
            `TSO_OFF_CMPB:   rd_val[15:0] = s_q.cmp_b;
            `TSO_OFF_STATUS: begin
                rd_val[`TSO_ST_MATCH_A] = s_q.flag_a;
                rd_val[`TSO_ST_MATCH_B] = s_q.flag_b;
                rd_val[`TSO_ST_OVF]     = s_q.ovf;
                rd_val[`TSO_ST_ACTIVE]  = s_q.active;
            end
            default: rd_val = '0;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        s_d.irq_a = 1'b0;
        s_d.irq_b = 1'b0;
        s_d.div = s_q.div + `TSO_DIV_W'(1);

        // Equality only, so a compare below the count waits for wrap
        if (tick) begin
            if (match_a && (s_q.mode == tso_pkg::TSO_MATCH_CLR)) begin
                s_d.count = `TSO_RST_COUNT;
            end else begin
                s_d.count = s_q.count + 16'h0001;
            end
        end

        if (match_a && s_q.tog && !s_q.os_en) begin
            s_d.out = ~s_q.out;
        end

        if (s_q.active && tick && s_q.count == lo) begin
            s_d.out = 1'b1;
        end
        if (s_q.active && tick && s_q.count == hi) begin
            s_d.out = 1'b0;
            s_d.active = 1'b0;
        end

        if (trig_clear) begin
            s_d.count = `TSO_RST_COUNT;
            s_d.active = ext_os;
            s_d.out = ext_os ? 1'b0 : s_d.out;
        end

        if (valid_edge && b_cap_eff) begin
            // Capture beats a CMPB write in the same cycle
            s_d.cmp_b = s_q.count;
        end

        if (wr && mapped) begin
            case (paddr)
                `TSO_OFF_MODE: begin
                    s_d.mode = tso_pkg::tso_mode_t'(
                        pwdata[`TSO_MODE_HI:`TSO_MODE_LO]);
                    if (s_d.mode == tso_pkg::TSO_STOP) begin
                        s_d.count = `TSO_RST_COUNT;
                        s_d.active = 1'b0;
                    end else if (!running) begin
                        s_d.count = `TSO_RST_COUNT;
                    end
                end
                `TSO_OFF_CAPCMP: begin
                    s_d.a_cap = pwdata[`TSO_CC_A_CAP];
                    s_d.b_cap = pwdata[`TSO_CC_B_CAP];
                end
                `TSO_OFF_OUTCTL: begin
                    s_d.oe     = pwdata[`TSO_OC_OE];
                    s_d.tog    = pwdata[`TSO_OC_TOG];
                    s_d.os_en  = pwdata[`TSO_OC_OS_EN];
                    s_d.ext_en = pwdata[`TSO_OC_EXT_EN];
                    if (sw_trig) begin
                        s_d.count = `TSO_RST_COUNT;
                        s_d.active = 1'b1;
                        s_d.out = 1'b0;
                    end
                end
                `TSO_OFF_PRESC: begin
                    s_d.div_sel = pwdata[`TSO_PR_DIV_HI:`TSO_PR_DIV_LO];
                    s_d.edge_sel = tso_pkg::tso_edge_t'(
                        pwdata[`TSO_PR_ES_HI:`TSO_PR_ES_LO]);
                end
                `TSO_OFF_CMPA: s_d.cmp_a = pwdata[15:0];
                `TSO_OFF_CMPB: begin
                    if (!(valid_edge && b_cap_eff)) begin
                        s_d.cmp_b = pwdata[15:0];
                    end
                end
                `TSO_OFF_STATUS: begin
                    s_d.flag_a = s_q.flag_a & ~pwdata[`TSO_ST_MATCH_A];
                    s_d.flag_b = s_q.flag_b & ~pwdata[`TSO_ST_MATCH_B];
                    s_d.ovf    = s_q.ovf & ~pwdata[`TSO_ST_OVF];
                end
                default: s_d.mode = s_q.mode;
            endcase
        end

        // Hardware sets come after the clear so a same-cycle event wins
        if (match_a) begin
            s_d.flag_a = 1'b1;
            s_d.irq_a = 1'b1;
        end
        if (match_b || (valid_edge && b_cap_eff)) begin
            s_d.flag_b = 1'b1;
            s_d.irq_b = 1'b1;
        end
        if (tick && s_q.count == `TSO_CNT_MAX && s_d.count == 16'h0000) begin
            s_d.ovf = 1'b1;
        end

        s_d.out = s_d.out & s_d.oe;

        if (setup && !pwrite) begin
            s_d.rdata = rd_val;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata       = s_q.rdata;
    assign timer_output = s_q.out;
    assign match_a_irq  = s_q.irq_a;
    assign match_b_irq  = s_q.irq_b;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_square_toggle: assert property (
        @(posedge pclk) disable iff (!presetn)
        match_a && s_q.oe && s_q.tog && !s_q.os_en && !wr
        |=> timer_output != $past(timer_output)
    ) else $error("square wave did not toggle on match");

    chk_sw_trig_start: assert property (
        @(posedge pclk) disable iff (!presetn)
        sw_trig |=> s_q.count == 16'h0000 && s_q.active
    ) else $error("software trigger did not clear and arm");

    chk_pulse_open: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_q.active && s_q.oe && tick && s_q.count == lo && lo != hi &&
        !wr && !trig_clear |=> timer_output
    ) else $error("one-shot output not active at first compare");

    chk_pulse_close: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_q.active && tick && s_q.count == hi && !wr && !trig_clear
        |=> !timer_output && !s_q.active
    ) else $error("one-shot output not ended at second compare");

    chk_stop_halts: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_q.mode == tso_pkg::TSO_STOP && !wr
        |=> s_q.count == $past(s_q.count)
    ) else $error("counter moved while stopped");

    chk_ext_ignore: assert property (
        @(posedge pclk) disable iff (!presetn)
        ext_os && s_q.active && valid_edge && !tick && !wr
        |=> s_q.count == $past(s_q.count)
    ) else $error("trigger edge restarted an active pulse");

    chk_start_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == `TSO_OFF_MODE && !running &&
        pwdata[`TSO_MODE_HI:`TSO_MODE_LO] != 2'h0
        |=> s_q.count == 16'h0000 ##[1:16] s_q.count == 16'h0001
    ) else $error("counter did not start from zero");

    chk_wrap_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        tick && s_q.count == 16'hFFFF && !wr && !trig_clear
        |=> s_q.count == 16'h0000 && s_q.ovf
    ) else $error("counter did not wrap past maximum");

    chk_capture_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        valid_edge && b_cap_eff |=> s_q.flag_b && match_b_irq
    ) else $error("capture did not raise match B request");

    chk_match_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        match_a && s_q.mode == tso_pkg::TSO_MATCH_CLR && !wr &&
        !trig_clear |=> s_q.count == 16'h0000 && match_a_irq
    ) else $error("match A did not clear and request");

    chk_match_b_req: assert property (
        @(posedge pclk) disable iff (!presetn)
        match_b |=> match_b_irq ##1 !match_b_irq
    ) else $error("match B request not a single pulse");

endmodule

// file: tso_pin_model.sv
/* Far side of the timer pins: a trigger source and an output load.
   Assumes both pins are synchronous to pclk. */
module tso_pin_model (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Pins
    input  wire logic timer_output,
    output logic      trigger_input
);
    timeunit 1ns;
    timeprecision 1ps;
    int   pulses = 0;
    int   width  = 0;
    int   run    = 0;
    logic last   = 1'b0;

    initial trigger_input = 1'b0;

    // Level moves just after an edge, as a synchronous source would
    task automatic set_pin(input logic v);
        @(posedge pclk);
        trigger_input <= v;
    endtask

    // Load counts pulses and the width of the last one in pclk
    always @(posedge pclk) begin
        if (!presetn) begin
            last <= 1'b0;
            run  <= 0;
        end else begin
            last <= timer_output;
            if (timer_output === 1'b1 && last !== 1'b1)
                pulses <= pulses + 1;
            if (timer_output === 1'b1)
                run <= run + 1;
            else
                run <= 0;
            if (timer_output !== 1'b1 && last === 1'b1)
                width <= run;
        end
    end
endmodule

// file: testbench.sv
/* Self-checking bench of the timer: APB master and pin partner.
   Assumes the zero-wait APB slave and count divide by 2. */
`include "tso_params.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ***
    // Signals
    // ***
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        trigger_input;
    logic        timer_output;
    logic        match_a_irq;
    logic        match_b_irq;
    logic [31:0] rd;
    logic        err;
    int          num_errors = 0;
    int          compares   = 0;

    tso_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trigger_input(trigger_input),
        .timer_output(timer_output), .match_a_irq(match_a_irq),
        .match_b_irq(match_b_irq));
    tso_pin_model pin (.pclk(pclk), .presetn(presetn),
        .timer_output(timer_output), .trigger_input(trigger_input));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // ***
    // Tasks
    // ***
    task automatic give_verdict();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check_word(input string nm, input logic [31:0] e,
                              input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        check_word("pready", 1, n < 100);
        if (n >= 100)
            give_verdict();
    endtask

    // 0 output high, 1 output low, 2 match A, 3 match B
    task automatic wait_for(input int w);
        logic s;
        int   n;
        s = 1'b0;
        for (n = 0; n < 400 && s !== 1'b1; n++) begin
            @(posedge pclk);
            #1;
            s = (w == 0) ? timer_output : (w == 1) ? !timer_output :
                (w == 2) ? match_a_irq : match_b_irq;
        end
        check_word("wait", 1, s);
        if (s !== 1'b1)
            give_verdict();
    endtask
    // ***
    // Scenarios
    // ***
    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            check_word("reset value", 32'h0, rd);
        end
        apb(1'b1, 8'h20, 32'hFFFFFFFF);
        check_word("unmapped write err", 1, err);
        apb(1'b0, 8'h20, 32'h0);
        check_word("unmapped read err", 1, err);
        check_word("unmapped read", 32'h0, rd);
    endtask

    task automatic t_square();
        apb(1'b1, `TSO_OFF_CMPA, 32'h3);
        apb(1'b1, `TSO_OFF_PRESC, 32'h0);
        apb(1'b1, `TSO_OFF_MODE, 32'hC);
        apb(1'b1, `TSO_OFF_OUTCTL, 32'h3);
        wait_for(0);
        wait_for(1);
        // The load latches the width one edge after the fall
        @(posedge pclk);
        #1;
        check_word("toggle width", 8, pin.width);
        wait_for(2);
        apb(1'b0, `TSO_OFF_COUNT, 32'h0);
        check_word("count after match", 1, rd <= 3);
        apb(1'b1, `TSO_OFF_MODE, 32'h0);
    endtask

    task automatic t_sw(input int n, input int m);
        logic [31:0] r1;
        apb(1'b1, `TSO_OFF_CMPA, 32'(m));
        apb(1'b1, `TSO_OFF_CMPB, 32'(n));
        apb(1'b1, `TSO_OFF_MODE, 32'h4);
        apb(1'b1, `TSO_OFF_OUTCTL, 32'h51);
        wait_for(n < m ? 3 : 2);
        check_word("pulse on", 1, timer_output);
        wait_for(n < m ? 2 : 3);
        check_word("pulse off", 0, timer_output);
        @(posedge pclk);
        #1;
        check_word("pulse width", 2 * (n < m ? m - n : n - m),
                   pin.width);
        apb(1'b0, `TSO_OFF_STATUS, 32'h0);
        check_word("status after pulse", 32'h3, rd);
        apb(1'b1, `TSO_OFF_STATUS, 32'h7);
        apb(1'b0, `TSO_OFF_STATUS, 32'h0);
        check_word("status cleared", 32'h0, rd);
        apb(1'b0, `TSO_OFF_COUNT, 32'h0);
        r1 = rd;
        apb(1'b0, `TSO_OFF_COUNT, 32'h0);
        check_word("count runs on", 1, rd !== r1);
        apb(1'b1, `TSO_OFF_MODE, 32'h0);
        apb(1'b0, `TSO_OFF_COUNT, 32'h0);
        check_word("count stopped", 32'h0, rd);
    endtask

    task automatic t_cap();
        apb(1'b1, `TSO_OFF_MODE, 32'h0);
        apb(1'b1, `TSO_OFF_PRESC, 32'h10);
        apb(1'b1, `TSO_OFF_CMPB, 32'hFFFF);
        apb(1'b1, `TSO_OFF_CAPCMP, 32'h4);
        apb(1'b1, `TSO_OFF_MODE, 32'h4);
        pin.set_pin(1'b1);
        wait_for(3);
        apb(1'b0, `TSO_OFF_CMPB, 32'h0);
        check_word("captured count", 1, rd < 32'h10);
        pin.set_pin(1'b0);
        repeat (20) @(posedge pclk);
        apb(1'b1, `TSO_OFF_CAPCMP, 32'h0);
    endtask

    task automatic t_ext(input tso_pkg::tso_edge_t e, input int gap,
                         input int hi, input int tot);
        int p0;
        apb(1'b1, `TSO_OFF_MODE, 32'h0);
        apb(1'b1, `TSO_OFF_PRESC, 32'(e) << `TSO_PR_ES_LO);
        apb(1'b1, `TSO_OFF_CMPA, 32'd12);
        apb(1'b1, `TSO_OFF_CMPB, 32'd2);
        apb(1'b1, `TSO_OFF_CAPCMP, 32'h0);
        apb(1'b1, `TSO_OFF_MODE, 32'h8);
        apb(1'b1, `TSO_OFF_OUTCTL, 32'h31);
        p0 = pin.pulses;
        pin.set_pin(1'b1);
        repeat (gap) @(posedge pclk);
        if (hi >= 0)
            check_word("pulses after rise", hi, pin.pulses - p0);
        pin.set_pin(1'b0);
        repeat (60) @(posedge pclk);
        check_word("pulses total", tot, pin.pulses - p0);
        if (tot > 0)
            check_word("ext width", 20, pin.width);
    endtask
    // ***
    // Main sequence
    // ***
    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_square();
        t_sw(2, 6);
        t_sw(6, 2);
        t_cap();
        t_ext(tso_pkg::TSO_EDGE_RISE, 60, 1, 1);
        t_ext(tso_pkg::TSO_EDGE_FALL, 60, 0, 1);
        t_ext(tso_pkg::TSO_EDGE_BOTH, 60, 1, 2);
        t_ext(tso_pkg::TSO_EDGE_NONE, 60, 0, 0);
        t_ext(tso_pkg::TSO_EDGE_BOTH, 10, -1, 1);
        give_verdict();
    end
endmodule
